// ==== rtl/uv_stage_cfg.svh ====
`ifndef UV_STAGE_CFG_SVH
`define UV_STAGE_CFG_SVH

// Timing
`define UV_CLK_PERIOD_NS   10
`define UV_EVAL_TICK_NS    5000000
`define UV_STAGES          4
`define UV_MAX_TICKS       19'd360000
`define UV_Q16_ONE         17'h10000
`define UV_HYST_PCT        103

// Per-stage register offsets (stage base is stage * 0x40)
`define UV_OFF_CTRL        4'h0
`define UV_OFF_PICKUP      4'h1
`define UV_OFF_BLOCKLVL    4'h2
`define UV_OFF_DT_DELAY    4'h3
`define UV_OFF_TDIAL       4'h4
`define UV_OFF_EXPONENT    4'h5
`define UV_OFF_RELEASE     4'h6
`define UV_OFF_STATUS      4'h7
`define UV_OFF_EXPECTED    4'h8
`define UV_OFF_REMAIN      4'h9
`define UV_OFF_RATIO_A     4'ha
`define UV_OFF_RATIO_B     4'hb
`define UV_OFF_RATIO_C     4'hc
`define UV_OFF_RATIO_MIN   4'hd
`define UV_OFF_PICK_PRIM   4'he
`define UV_OFF_BLK_PRIM    4'hf
`define UV_ADDR_VT_SCALE   9'h100

// Control fields
`define UV_CTRL_MODE_LSB   0
`define UV_CTRL_INVERSE_TIME_MODE_BIT   3
`define UV_CTRL_DREL_BIT   4
`define UV_CTRL_TRST_BIT   5
`define UV_CTRL_CONT_BIT   6

// Reset values
`define UV_RST_CTRL        7'h30
`define UV_RST_PICKUP      16'h1770
`define UV_RST_BLOCKLVL    16'h03e8
`define UV_RST_DT_DELAY    19'h00008
`define UV_RST_TDIAL       13'h0005
`define UV_RST_EXPONENT    12'h064
`define UV_RST_RELEASE     15'h000c
`define UV_RST_VT_SCALE    32'h0000_03e8

`endif

// ==== rtl/uv_stage_pkg.sv ====
package uv_stage_pkg;

  typedef enum logic [2:0] {
    MODE_ON           = 3'h0,
    MODE_BLOCKED      = 3'h1,
    MODE_TEST         = 3'h2,
    MODE_TEST_BLOCKED = 3'h3,
    MODE_OFF          = 3'h4
  } stage_mode_type;

  typedef enum logic [2:0] {
    E_IDLE  = 3'b000,
    E_LOAD  = 3'b001,
    E_DIV   = 3'b011,
    E_STORE = 3'b010,
    E_POW   = 3'b110,
    E_FRAC  = 3'b111,
    E_NEXT  = 3'b101
  } eng_state_type;

endpackage

// ==== rtl/uv_stage.sv ====
// Operation
// - blocking input is sampled once at the start of every evaluation tick
// - pick-up with blocking inactive raises start and begins operate timing
// - pick-up with blocking active raises blocked and does no trip timing
// - blocking arriving while start is set runs release handling, so start follows the delayed release setting
// - instant operation trips in the same tick as start
// - fixed delay mode trips after set delay of continuous pick-up
// - inverse mode time is dial over one minus ratio to exponent
// - delay type selects fixed or inverse time, fixed by default
// - fixed delay in 5 ms steps, default 40 ms, zero means instant
// - time dial used only in inverse mode, 0.01 s steps, default 0.05
// - exponent in 0.01 steps, default 1.00, used only in inverse mode
// - release delay in 5 ms steps, default 60 ms, start held meanwhile
// - delayed release keeps start for release time, else drops at once
// - timer reset after release clears timer only after full release time
// - continue option keeps operate timer running through release time
// - remaining time to trip reported signed in 5 ms units
// - expected operate time reported, recomputed each tick in inverse mode
// - ratio of each voltage and lowest voltage to threshold, 0.01 steps
// - below block level tripping is inhibited until voltage exceeds pick-up
// - pick-up and block levels reported as primary volts in 0.1 V
// - current stage mode reported: on, blocked, test, test-blocked, off
// - pick-up releases at 103 percent of threshold
// - four independent stages with own settings and outputs
`timescale 1ns/10ps
`include "uv_stage_cfg.svh"

module uv_stage #(
  parameter int TICK_CYCLES = `UV_EVAL_TICK_NS / `UV_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Measurements, 0.01 %Un, same clock domain
  input  wire logic [15:0] meas_a,
  input  wire logic [15:0] meas_b,
  input  wire logic [15:0] meas_c,
  // Blocking matrix, asynchronous
  input  wire logic [3:0]  ext_block,
  // Stage outputs
  output logic [3:0]       start_o,
  output logic [3:0]       trip_o,
  output logic [3:0]       blocked_o
);

  localparam int NS = `UV_STAGES;

  // Settings
  logic [6:0]  ctrl_reg     [NS];
  logic [15:0] pickup_reg   [NS];
  logic [15:0] blocklvl_reg [NS];
  logic [18:0] dt_reg       [NS];
  logic [12:0] tdial_reg    [NS];
  logic [11:0] expo_reg     [NS];
  logic [14:0] release_reg  [NS];
  logic [31:0] vt_scale_reg;

  // Engine results
  logic [15:0] ratio_reg [NS*4];
  logic [18:0] expect_reg [NS];

  // Stage state, flattened for the read mux
  logic [3:0]  inhibit_w;
  logic [3:0]  pick_w;
  logic [19:0] remain_w [NS];

  // Tick and block synchroniser
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;
  logic [3:0]  blk_meta_reg;
  logic [3:0]  blk_sync_reg;
  logic [3:0]  blk_smp_reg;

  // AHB state
  logic        wr_pend_reg;
  logic [8:0]  wr_addr_reg;

  function automatic logic [15:0] min3(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
    logic [15:0] m;
    m = (a < b) ? a : b;
    return (m < c) ? m : c;
  endfunction

  function automatic logic [31:0] prim(input logic [15:0] lvl, input logic [31:0] scale);
    logic [47:0] p;
    p = 48'(lvl) * 48'(scale) / 48'd10000;
    return p[31:0];
  endfunction

  wire [15:0] vmin_w = min3(meas_a, meas_b, meas_c);

  // Evaluation tick and blocking sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_reg <= 32'h0;
      tick_reg     <= 1'b0;
      blk_meta_reg <= 4'h0;
      blk_sync_reg <= 4'h0;
      blk_smp_reg  <= 4'h0;
    end else begin
      blk_meta_reg <= ext_block;
      blk_sync_reg <= blk_meta_reg;
      tick_reg     <= (tick_cnt_reg == 32'(TICK_CYCLES - 1));
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_reg + 32'h1;
      if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
        blk_smp_reg <= blk_sync_reg;
      end
    end
  end

  // AHB decode
  wire        addr_ok  = hsel & htrans[1] & hready;
  wire        is_glob  = (haddr[8:0] == `UV_ADDR_VT_SCALE);
  wire        in_stage = (haddr[31:8] == 24'h0);
  wire [1:0]  rd_stg   = haddr[7:6];
  wire [3:0]  rd_idx   = haddr[5:2];
  wire [1:0]  wr_stg   = wr_addr_reg[7:6];
  wire [3:0]  wr_idx   = wr_addr_reg[5:2];
  wire        wr_stage = ~wr_addr_reg[8];
  wire        wr_glob  = (wr_addr_reg == `UV_ADDR_VT_SCALE);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (is_glob) begin
      rd_mux = vt_scale_reg;
    end else if (in_stage) begin
      case (rd_idx)
        `UV_OFF_CTRL:      rd_mux = {25'h0, ctrl_reg[rd_stg]};
        `UV_OFF_PICKUP:    rd_mux = {16'h0, pickup_reg[rd_stg]};
        `UV_OFF_BLOCKLVL:  rd_mux = {16'h0, blocklvl_reg[rd_stg]};
        `UV_OFF_DT_DELAY:  rd_mux = {13'h0, dt_reg[rd_stg]};
        `UV_OFF_TDIAL:     rd_mux = {19'h0, tdial_reg[rd_stg]};
        `UV_OFF_EXPONENT:  rd_mux = {20'h0, expo_reg[rd_stg]};
        `UV_OFF_RELEASE:   rd_mux = {17'h0, release_reg[rd_stg]};
        `UV_OFF_STATUS:    rd_mux = {24'h0, ctrl_reg[rd_stg][2:0], inhibit_w[rd_stg], pick_w[rd_stg],
                                     blocked_o[rd_stg], trip_o[rd_stg], start_o[rd_stg]};
        `UV_OFF_EXPECTED:  rd_mux = {13'h0, ctrl_reg[rd_stg][`UV_CTRL_INVERSE_TIME_MODE_BIT] ?
                                     expect_reg[rd_stg] : dt_reg[rd_stg]};
        `UV_OFF_REMAIN:    rd_mux = {{12{remain_w[rd_stg][19]}}, remain_w[rd_stg]};
        `UV_OFF_RATIO_A:   rd_mux = {16'h0, ratio_reg[{rd_stg, 2'd0}]};
        `UV_OFF_RATIO_B:   rd_mux = {16'h0, ratio_reg[{rd_stg, 2'd1}]};
        `UV_OFF_RATIO_C:   rd_mux = {16'h0, ratio_reg[{rd_stg, 2'd2}]};
        `UV_OFF_RATIO_MIN: rd_mux = {16'h0, ratio_reg[{rd_stg, 2'd3}]};
        `UV_OFF_PICK_PRIM: rd_mux = prim(pickup_reg[rd_stg], vt_scale_reg);
        `UV_OFF_BLK_PRIM:  rd_mux = prim(blocklvl_reg[rd_stg], vt_scale_reg);
        default:           rd_mux = 32'h0;
      endcase
    end
  end

  // AHB slave: zero wait states, reads registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      hrdata       <= 32'h0;
      wr_pend_reg  <= 1'b0;
      wr_addr_reg  <= 9'h0;
      vt_scale_reg <= `UV_RST_VT_SCALE;
      for (int i = 0; i < NS; i++) begin
        ctrl_reg[i]     <= `UV_RST_CTRL;
        pickup_reg[i]   <= `UV_RST_PICKUP;
        blocklvl_reg[i] <= `UV_RST_BLOCKLVL;
        dt_reg[i]       <= `UV_RST_DT_DELAY;
        tdial_reg[i]    <= `UV_RST_TDIAL;
        expo_reg[i]     <= `UV_RST_EXPONENT;
        release_reg[i]  <= `UV_RST_RELEASE;
      end
    end else begin
      wr_pend_reg <= addr_ok & hwrite & (in_stage | is_glob);
      wr_addr_reg <= haddr[8:0];
      if (addr_ok & ~hwrite) begin
        hrdata <= rd_mux;
      end
      if (wr_pend_reg & wr_glob) begin
        vt_scale_reg <= hwdata;
      end
      if (wr_pend_reg & wr_stage) begin
        case (wr_idx)
          `UV_OFF_CTRL:     ctrl_reg[wr_stg]     <= hwdata[6:0];
          `UV_OFF_PICKUP:   pickup_reg[wr_stg]   <= hwdata[15:0];
          `UV_OFF_BLOCKLVL: blocklvl_reg[wr_stg] <= hwdata[15:0];
          `UV_OFF_DT_DELAY: dt_reg[wr_stg]       <= hwdata[18:0];
          `UV_OFF_TDIAL:    tdial_reg[wr_stg]    <= hwdata[12:0];
          `UV_OFF_EXPONENT: expo_reg[wr_stg]     <= hwdata[11:0];
          `UV_OFF_RELEASE:  release_reg[wr_stg]  <= hwdata[14:0];
          default:          ;
        endcase
      end
    end
  end

  // Shared ratio and inverse-time engine, one pass over all stages per tick.
  // A serial divider keeps area small; a pass takes roughly 830 cycles.
  uv_stage_pkg::eng_state_type eng_reg;
  logic [1:0]  stg_reg;
  logic [2:0]  job_reg;
  logic [31:0] num_reg;
  logic [31:0] quo_reg;
  logic [32:0] rem_reg;
  logic [4:0]  bit_reg;
  logic [16:0] rq_reg;
  logic [16:0] pow_reg;
  logic [4:0]  pcnt_reg;

  wire [15:0] us_w     = pickup_reg[stg_reg];
  wire [4:0]  expo_int = 5'(expo_reg[stg_reg] / 12'd100);
  wire [6:0]  expo_frc = 7'(expo_reg[stg_reg] % 12'd100);
  wire [33:0] pow_mul  = 34'(pow_reg) * 34'(rq_reg);
  wire [33:0] frc_mul  = 34'(pow_reg) * 34'(`UV_Q16_ONE - rq_reg);
  wire [40:0] frc_adj  = 41'(frc_mul[33:16]) * 41'(expo_frc) / 41'd100;
  wire [32:0] rem_sh   = {rem_reg[31:0], num_reg[31]};
  wire [32:0] den_w    = (job_reg == 3'd5) ? 33'(`UV_Q16_ONE - pow_reg) : 33'(us_w);

  logic [31:0] job_num;
  always_comb begin
    case (job_reg)
      3'd0:    job_num = 32'(meas_a) * 32'd100;
      3'd1:    job_num = 32'(meas_b) * 32'd100;
      3'd2:    job_num = 32'(meas_c) * 32'd100;
      3'd3:    job_num = 32'(vmin_w) * 32'd100;
      3'd4:    job_num = {vmin_w, 16'h0};
      default: job_num = 32'(tdial_reg[stg_reg]) * 32'd131072; // 0.01 s = 2 ticks, Q16
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_reg  <= uv_stage_pkg::E_IDLE;
      stg_reg  <= 2'd0;
      job_reg  <= 3'd0;
      num_reg  <= 32'h0;
      quo_reg  <= 32'h0;
      rem_reg  <= 33'h0;
      bit_reg  <= 5'd0;
      rq_reg   <= 17'h0;
      pow_reg  <= 17'h0;
      pcnt_reg <= 5'd0;
      for (int i = 0; i < NS*4; i++) begin
        ratio_reg[i] <= 16'h0;
      end
      for (int i = 0; i < NS; i++) begin
        expect_reg[i] <= `UV_MAX_TICKS;
      end
    end else begin
      case (eng_reg)
        uv_stage_pkg::E_IDLE: begin
          stg_reg <= 2'd0;
          job_reg <= 3'd0;
          if (tick_reg) begin
            eng_reg <= uv_stage_pkg::E_LOAD;
          end
        end
        uv_stage_pkg::E_LOAD: begin
          num_reg <= job_num;
          rem_reg <= 33'h0;
          quo_reg <= 32'h0;
          bit_reg <= 5'd0;
          eng_reg <= uv_stage_pkg::E_DIV;
        end
        uv_stage_pkg::E_DIV: begin
          // Divide by zero saturates the quotient to all ones
          num_reg <= {num_reg[30:0], 1'b0};
          if (rem_sh >= den_w) begin
            rem_reg <= rem_sh - den_w;
            quo_reg <= {quo_reg[30:0], 1'b1};
          end else begin
            rem_reg <= rem_sh;
            quo_reg <= {quo_reg[30:0], 1'b0};
          end
          bit_reg <= bit_reg + 5'd1;
          if (bit_reg == 5'd31) begin
            eng_reg <= uv_stage_pkg::E_STORE;
          end
        end
        uv_stage_pkg::E_STORE: begin
          if (job_reg < 3'd4) begin
            ratio_reg[{stg_reg, job_reg[1:0]}] <= (quo_reg > 32'hffff) ? 16'hffff : quo_reg[15:0];
            job_reg <= job_reg + 3'd1;
            eng_reg <= uv_stage_pkg::E_LOAD;
          end else if (job_reg == 3'd4) begin
            rq_reg   <= (quo_reg > 32'(`UV_Q16_ONE)) ? `UV_Q16_ONE : quo_reg[16:0];
            pow_reg  <= `UV_Q16_ONE;
            pcnt_reg <= 5'd0;
            job_reg  <= 3'd5;
            eng_reg  <= uv_stage_pkg::E_POW;
          end else begin
            expect_reg[stg_reg] <= (quo_reg > 32'(`UV_MAX_TICKS)) ? `UV_MAX_TICKS : quo_reg[18:0];
            eng_reg <= uv_stage_pkg::E_NEXT;
          end
        end
        uv_stage_pkg::E_POW: begin
          // Whole part of the exponent by repeated multiply
          if (pcnt_reg < expo_int) begin
            pow_reg  <= pow_mul[32:16];
            pcnt_reg <= pcnt_reg + 5'd1;
          end else begin
            eng_reg <= uv_stage_pkg::E_FRAC;
          end
        end
        uv_stage_pkg::E_FRAC: begin
          // Fraction by first-order step; close enough below ratio one
          pow_reg <= pow_reg - 17'(frc_adj);
          eng_reg <= uv_stage_pkg::E_LOAD;
        end
        uv_stage_pkg::E_NEXT: begin
          job_reg <= 3'd0;
          stg_reg <= stg_reg + 2'd1;
          eng_reg <= (stg_reg == 2'd3) ? uv_stage_pkg::E_IDLE : uv_stage_pkg::E_LOAD;
        end
        default: eng_reg <= uv_stage_pkg::E_IDLE;
      endcase
    end
  end

  // Four independent stages
  for (genvar g = 0; g < NS; g++) begin : stage_g
    logic        start_reg;
    logic        trip_reg;
    logic        blocked_reg;
    logic        pick_reg;
    logic        inhibit_reg;
    logic        rel_reg;
    logic [18:0] op_reg;
    logic [14:0] relc_reg;

    wire [2:0]  mode_w   = ctrl_reg[g][2:0];
    wire        off_w    = (mode_w >= uv_stage_pkg::MODE_OFF);
    wire        blk_w    = blk_smp_reg[g] | (mode_w == uv_stage_pkg::MODE_BLOCKED) |
                           (mode_w == uv_stage_pkg::MODE_TEST_BLOCKED);
    wire        inverse_time_mode_w   = ctrl_reg[g][`UV_CTRL_INVERSE_TIME_MODE_BIT];
    wire        drel_w   = ctrl_reg[g][`UV_CTRL_DREL_BIT];
    wire        trst_w   = ctrl_reg[g][`UV_CTRL_TRST_BIT];
    wire        cont_w   = ctrl_reg[g][`UV_CTRL_CONT_BIT];
    wire [18:0] target_w = inverse_time_mode_w ? expect_reg[g] : dt_reg[g];
    wire [18:0] op_inc   = (op_reg == `UV_MAX_TICKS) ? op_reg : op_reg + 19'd1;
    wire [31:0] hyst_w   = 32'(pickup_reg[g]) * 32'(`UV_HYST_PCT) / 32'd100;
    wire        pick_set = vmin_w < pickup_reg[g];
    wire        pick_clr = 32'(vmin_w) > hyst_w;
    wire        active_w = pick_reg & ~inhibit_reg;
    wire        rel_done = 15'(relc_reg + 15'd1) >= release_reg[g];

    assign pick_w[g]    = pick_reg;
    assign inhibit_w[g] = inhibit_reg;
    assign remain_w[g]  = 20'(target_w) - 20'(op_reg);
    assign start_o[g]   = start_reg;
    assign trip_o[g]    = trip_reg;
    assign blocked_o[g] = blocked_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        start_reg   <= 1'b0;
        trip_reg    <= 1'b0;
        blocked_reg <= 1'b0;
        pick_reg    <= 1'b0;
        inhibit_reg <= 1'b0;
        rel_reg     <= 1'b0;
        op_reg      <= 19'h0;
        relc_reg    <= 15'h0;
      end else if (tick_reg) begin
        if (pick_set) begin
          pick_reg <= 1'b1;
        end else if (pick_clr) begin
          pick_reg <= 1'b0;
        end
        if ((blocklvl_reg[g] != 16'h0) && (vmin_w < blocklvl_reg[g])) begin
          inhibit_reg <= 1'b1;
        end else if (vmin_w > pickup_reg[g]) begin
          inhibit_reg <= 1'b0;
        end
        if (off_w) begin
          start_reg   <= 1'b0;
          trip_reg    <= 1'b0;
          blocked_reg <= 1'b0;
          rel_reg     <= 1'b0;
          op_reg      <= 19'h0;
          relc_reg    <= 15'h0;
        end else if (active_w && !blk_w) begin
          start_reg   <= 1'b1;
          blocked_reg <= 1'b0;
          rel_reg     <= 1'b0;
          relc_reg    <= 15'h0;
          op_reg      <= op_inc;
          trip_reg    <= (op_inc >= target_w) || (target_w == 19'h0);
        end else begin
          blocked_reg <= active_w & blk_w;
          trip_reg    <= 1'b0;
          if ((start_reg || rel_reg) && !rel_reg) begin
            // First tick of release, also entered when blocking arrives
            rel_reg  <= 1'b1;
            relc_reg <= 15'h0;
            start_reg <= drel_w & (release_reg[g] != 15'h0);
            if (!trst_w) begin
              op_reg <= 19'h0;
            end
          end else if (rel_reg) begin
            relc_reg <= relc_reg + 15'd1;
            if (cont_w) begin
              op_reg <= op_inc;
            end
            if (rel_done) begin
              rel_reg   <= 1'b0;
              start_reg <= 1'b0;
              if (trst_w) begin
                op_reg <= 19'h0;
              end
            end
          end
        end
      end
    end
  end

endmodule

// ==== verif/uv_field_model.sv ====
`timescale 1ns/10ps
module uv_field_model (
  // Commands from the bench
  input  wire logic [15:0] level,
  input  wire logic [3:0]  block_req,
  // Into the stage block
  output logic      [15:0] meas_a,
  output logic      [15:0] meas_b,
  output logic      [15:0] meas_c,
  output logic      [3:0]  ext_block
);
  // Spread phases so phase A is always the lowest
  assign meas_a = level;
  assign meas_b = level + 16'h3c;
  assign meas_c = level + 16'h78;
  // Bench raises a block ticks ahead of any delay expiry
  assign ext_block = block_req;
endmodule

// ==== verif/uv_stage_checker.sv ====
`timescale 1ns/10ps
module uv_stage_checker #(
  parameter int TICK_CYCLES = 2000
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [3:0]  start_o,
  input wire logic [3:0]  trip_o,
  input wire logic [3:0]  blocked_o
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int          gap_reg;
  logic [11:0] outs_prev_reg;
  wire  [11:0] outs = {start_o, trip_o, blocked_o};
  // Cycles since any stage output last moved
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_reg       <= TICK_CYCLES;
      outs_prev_reg <= 12'h000;
    end else begin
      gap_reg       <= (outs != outs_prev_reg) ? 0 : ((gap_reg < TICK_CYCLES) ? gap_reg + 1 : gap_reg);
      outs_prev_reg <= outs;
    end
  end
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  a_ready_always: assert property (hreadyout) else $error("slave inserted wait state");
  a_rdata_hold: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_outs_per_tick: assert property ((outs != outs_prev_reg) |-> gap_reg >= TICK_CYCLES - 1)
    else $error("stage outputs moved between ticks");
  a_reset_quiet: assert property ($rose(hresetn) |-> outs == 12'h000)
    else $error("outputs active right after reset");
  for (genvar i = 0; i < 4; i++) begin : g_stage
    a_trip_with_start: assert property ($rose(trip_o[i]) |-> start_o[i])
      else $error("trip rose without start");
    a_start_unblocked: assert property ($rose(start_o[i]) |-> !blocked_o[i])
      else $error("start rose while blocked");
    a_blocked_no_trip: assert property (blocked_o[i] |-> !$rose(trip_o[i]))
      else $error("trip rose while blocked");
  end
endmodule
bind uv_stage uv_stage_checker #(.TICK_CYCLES(TICK_CYCLES)) i_uv_stage_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .start_o(start_o), .trip_o(trip_o),
  .blocked_o(blocked_o));

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`include "uv_stage_cfg.svh"
module tb;
  localparam int TC = 1500;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] meas_a;
  logic [15:0] meas_b;
  logic [15:0] meas_c;
  logic [3:0]  ext_block;
  logic [3:0]  start_o;
  logic [3:0]  trip_o;
  logic [3:0]  blocked_o;
  logic [3:0]  block_req;
  logic [15:0] level;
  logic [31:0] rd;
  int          err_count;
  int          num_checks;
  int          n;
  logic [3:0]  rv_off [9] = '{`UV_OFF_CTRL, `UV_OFF_PICKUP, `UV_OFF_BLOCKLVL, `UV_OFF_DT_DELAY, `UV_OFF_TDIAL,
                              `UV_OFF_EXPONENT, `UV_OFF_RELEASE, `UV_OFF_PICK_PRIM, `UV_OFF_BLK_PRIM};
  logic [31:0] rv_exp [9] = '{32'h30, 32'h1770, 32'h3e8, 32'h8, 32'h5, 32'h64, 32'hc, 32'h258, 32'h64};

  uv_stage #(.TICK_CYCLES(TC)) i_uv_stage (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .meas_a(meas_a), .meas_b(meas_b), .meas_c(meas_c), .ext_block(ext_block),
    .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o));
  uv_field_model i_uv_field_model (
    .level(level), .block_req(block_req), .meas_a(meas_a), .meas_b(meas_b), .meas_c(meas_c),
    .ext_block(ext_block));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  function automatic logic [31:0] ra(input int s, input logic [3:0] off);
    return 32'(s * 64) + {26'h0, off, 2'b00};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single AHB-Lite transfer; entered and left just after a rising edge
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    int k;
    k = 0;
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 100);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 100);
    rd = hrdata;
  endtask

  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic ticks(input int t);
    repeat (t * TC) @(posedge hclk);
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge hclk);
    err_count++;
    report_and_stop();
  end

  initial begin
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0;
    level      = 16'h2710;
    block_req  = 4'h0;
    err_count  = 0;
    num_checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 9; i++) begin
      rchk("reset value", ra(1, rv_off[i]), rv_exp[i]);
    end
    rchk("scale reset", 32'(`UV_ADDR_VT_SCALE), 32'h3e8);
    rchk("unmapped", 32'h104, 32'h0);
    // Stage 0 short delay, 1 instant, 2 blocked, 3 long delay with short release
    xfer(ra(0, `UV_OFF_DT_DELAY), 1'b1, 32'h2);
    xfer(ra(1, `UV_OFF_DT_DELAY), 1'b1, 32'h0);
    xfer(ra(3, `UV_OFF_DT_DELAY), 1'b1, 32'h64);
    xfer(ra(3, `UV_OFF_RELEASE), 1'b1, 32'h3);
    block_req <= 4'b0100;
    ticks(2);
    level <= 16'd3000;
    n = 0;
    // Outputs are read at the falling edge, away from the edge that launches them
    while (start_o[0] !== 1'b1 && n < 5 * TC) begin
      @(negedge hclk);
      n++;
    end
    check("start 0", 32'(start_o[0]), 32'h1);
    check("instant 1", 32'({start_o[1], trip_o[1]}), 32'h3);
    check("blocked 2", 32'({start_o[2], trip_o[2], blocked_o[2]}), 32'h1);
    check("start 3", 32'({start_o[3], trip_o[3]}), 32'h2);
    repeat (TC - 1) @(negedge hclk);
    check("trip 0 early", 32'(trip_o[0]), 32'h0);
    @(negedge hclk);
    check("trip 0", 32'(trip_o[0]), 32'h1);
    @(posedge hclk);
    for (int i = 0; i < 3; i++) begin
      rchk("ratio", ra(0, `UV_OFF_RATIO_A + 4'(i)), 32'(50 + i));
    end
    rchk("ratio min", ra(0, `UV_OFF_RATIO_MIN), 32'd50);
    rchk("status 0", ra(0, `UV_OFF_STATUS), 32'h0b);
    rchk("expected 0", ra(0, `UV_OFF_EXPECTED), 32'h2);
    // Block arriving during start keeps start for the release time only
    block_req <= 4'b1100;
    ticks(2);
    check("held 3", 32'({start_o[3], blocked_o[3]}), 32'h3);
    ticks(3);
    check("released 3", 32'(start_o[3]), 32'h0);
    // Stage 1 without delayed release drops at once, stage 0 holds
    xfer(ra(1, `UV_OFF_CTRL), 1'b1, 32'h20);
    level <= 16'd7000;
    ticks(3);
    check("fast drop 1", 32'(start_o[1]), 32'h0);
    check("slow drop 0", 32'(start_o[0]), 32'h1);
    xfer(ra(2, `UV_OFF_CTRL), 1'b1, 32'h34);
    ticks(1);
    xfer(ra(2, `UV_OFF_STATUS), 1'b0, 32'h0);
    check("mode 2", 32'(rd[7:5]), 32'h4);
    report_and_stop();
  end
endmodule
